// ### rtl/dmx_exec.sv
// Summary of operation
// RULE1: Pointer load writes 12-bit literal, flags untouched.
// RULE2: Pointer load: two words, high then low.
// RULE3: File move to working register or itself.
// RULE4: File move sets negative and zero flags.
// RULE5: Full move copies any address to any.
// RULE6: Full move decoded from 1100/1111 words, no flags.
// RULE7: Working register usable as full-move source/destination.
// RULE8: Software avoids PC-low and stack-top destinations.
// RULE9: Software avoids interrupt changes via full move.
// RULE10: Full move: read source, then write, no dummy read.
`include "dmx_regs.svh"
`default_nettype none
module dmx_exec
  import dmx_pkg::*;
#(
  parameter logic [11:0] WREG_ADDR = `DMX_WREG_DFLT
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // Instruction stream
  input  wire logic [15:0]       instr_word,
  input  wire logic              instr_valid,
  output logic                   instr_take,
  output logic [1:0]             q_phase,
  // Bank selection
  input  wire logic [7:0]        bank_select_reg,
  // Data space
  output logic [11:0]            mem_addr,
  output logic                   mem_rd,
  input  wire logic [7:0]        mem_rdata,
  output logic                   mem_wr,
  output logic [7:0]             mem_wdata,
  // Architectural state
  output logic [7:0]             w_reg,
  output logic                   flag_n,
  output logic                   flag_z,
  output logic [2:0][11:0]       indirect_pointer
);
  dmx_dec_if dec_if ();

  dmx_decoder u_dec (
    .word (instr_word),
    .dec  (dec_if)
  );

  logic [1:0]  q_r;
  dmx_exp_type exp_r;
  dmx_cyc_type cyc_r;
  logic [1:0]  sel_r;
  logic [3:0]  hi_r;
  logic [7:0]  lo_r;
  logic        dest_r;
  logic [11:0] src_r;
  logic [11:0] dst_r;
  logic [7:0]  data_r;
  logic [7:0]  w_r;
  logic        n_r;
  logic        z_r;
  logic [11:0] ptr_r [3];
  logic [11:0] fmove_addr;
  logic [7:0]  rd_data;
  logic        take_first;
  logic        take_ptr2;
  logic        take_full2;
  logic        bad_second;

  assign q_phase = q_r;
  assign w_reg   = w_r;
  assign flag_n  = n_r;
  assign flag_z  = z_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      q_r <= `DMX_Q1;
    end else begin
      q_r <= q_r + 2'h1;
    end
  end

  // Words are taken only at Q1; a missing second word stretches the instruction.
  assign take_first = (q_r == `DMX_Q1) && instr_valid && (exp_r == DMX_EXP_FIRST);
  assign take_ptr2  = (q_r == `DMX_Q1) && instr_valid && (exp_r == DMX_EXP_PTR2)
                      && dec_if.ptr_second; // RULE2
  assign take_full2 = (q_r == `DMX_Q1) && instr_valid && (exp_r == DMX_EXP_FULL2)
                      && dec_if.full_second; // RULE6
  assign bad_second = (q_r == `DMX_Q1) && instr_valid && (exp_r != DMX_EXP_FIRST)
                      && !take_ptr2 && !take_full2;
  assign instr_take = take_first || take_ptr2 || take_full2 || bad_second;

  // Access bank maps low offsets to the bottom bank and high ones to the top bank.
  always_comb begin
    if (dec_if.bank_bit) begin
      fmove_addr = {bank_select_reg[3:0], dec_if.low_byte}; // RULE3
    end else if (dec_if.low_byte < `DMX_ACCESS_SPLIT) begin
      fmove_addr = {`DMX_ACCESS_LO_BANK, dec_if.low_byte}; // RULE3
    end else begin
      fmove_addr = {`DMX_ACCESS_HI_BANK, dec_if.low_byte}; // RULE3
    end
  end

  // The working register answers at its own data-space address.
  assign rd_data = (mem_addr == WREG_ADDR) ? w_r : mem_rdata; // RULE7

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      exp_r <= DMX_EXP_FIRST;
    end else if (take_first && dec_if.op == DMX_OP_PTR) begin
      exp_r <= DMX_EXP_PTR2; // RULE2
    end else if (take_first && dec_if.op == DMX_OP_FULL) begin
      exp_r <= DMX_EXP_FULL2; // RULE10
    end else if (take_ptr2 || take_full2 || bad_second) begin
      exp_r <= DMX_EXP_FIRST;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cyc_r <= DMX_CY_IDLE;
    end else if (q_r == `DMX_Q1) begin
      if (take_first) begin
        case (dec_if.op)
          DMX_OP_PTR:   cyc_r <= DMX_CY_PTR1;
          DMX_OP_FMOVE: cyc_r <= DMX_CY_FMOVE;
          DMX_OP_FULL:  cyc_r <= DMX_CY_FULL1;
          default:      cyc_r <= DMX_CY_IDLE;
        endcase
      end else if (take_ptr2) begin
        cyc_r <= DMX_CY_PTR2;
      end else if (take_full2) begin
        cyc_r <= DMX_CY_FULL2;
      end else begin
        cyc_r <= DMX_CY_IDLE;
      end
    end
  end

  // Operand capture at Q1.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sel_r  <= 2'h0;
      hi_r   <= 4'h0;
      lo_r   <= 8'h00;
      dest_r <= 1'b0;
      src_r  <= 12'h000;
      dst_r  <= 12'h000;
    end else if (take_first) begin
      sel_r  <= dec_if.ptr_sel;
      hi_r   <= dec_if.imm_hi;
      dest_r <= dec_if.dest_bit;
      src_r  <= (dec_if.op == DMX_OP_FULL) ? dec_if.addr12 : fmove_addr; // RULE5
    end else if (take_ptr2) begin
      lo_r   <= dec_if.low_byte;
    end else if (take_full2) begin
      dst_r  <= dec_if.addr12; // RULE5
    end
  end

  // Data-space strobes: read in Q2, write in Q4, no read in the second full-move cycle.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_addr <= 12'h000;
      mem_rd   <= 1'b0;
    end else if (take_first && dec_if.op == DMX_OP_FMOVE) begin
      mem_addr <= fmove_addr; // RULE3
      mem_rd   <= (fmove_addr != WREG_ADDR);
    end else if (take_first && dec_if.op == DMX_OP_FULL) begin
      mem_addr <= dec_if.addr12; // RULE10
      mem_rd   <= (dec_if.addr12 != WREG_ADDR); // RULE7
    end else if (q_r == `DMX_Q3 && (cyc_r == DMX_CY_FULL2 ||
                 (cyc_r == DMX_CY_FMOVE && dest_r))) begin
      mem_addr <= (cyc_r == DMX_CY_FULL2) ? dst_r : src_r; // RULE10
      mem_rd   <= 1'b0;
    end else begin
      mem_rd   <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_r <= 8'h00;
    end else if (q_r == `DMX_Q2 && (cyc_r == DMX_CY_FMOVE || cyc_r == DMX_CY_FULL1)) begin
      data_r <= rd_data; // RULE10
    end
  end

  // Writes that land on the working register stay inside the block.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mem_wr    <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (q_r == `DMX_Q3 && cyc_r == DMX_CY_FULL2) begin
      mem_wr    <= (dst_r != WREG_ADDR); // RULE7
      mem_wdata <= data_r; // RULE5
    end else if (q_r == `DMX_Q3 && cyc_r == DMX_CY_FMOVE && dest_r) begin
      mem_wr    <= (src_r != WREG_ADDR); // RULE3
      mem_wdata <= data_r;
    end else begin
      mem_wr    <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      w_r <= `DMX_W_RST;
    end else if (q_r == `DMX_Q4 && cyc_r == DMX_CY_FMOVE
                 && (!dest_r || src_r == WREG_ADDR)) begin
      w_r <= data_r; // RULE3
    end else if (q_r == `DMX_Q4 && cyc_r == DMX_CY_FULL2 && dst_r == WREG_ADDR) begin
      w_r <= data_r; // RULE7
    end
  end

  // Only the file move touches the flags.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      n_r <= `DMX_FLAG_RST;
      z_r <= `DMX_FLAG_RST;
    end else if (q_r == `DMX_Q4 && cyc_r == DMX_CY_FMOVE) begin
      n_r <= data_r[7]; // RULE4
      z_r <= (data_r == 8'h00); // RULE4
    end
  end

  // Selector 3 names no pointer and writes nothing.
  for (genvar i = 0; i < 3; i++) begin : g_ptr
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        ptr_r[i] <= `DMX_PTR_RST;
      end else if (q_r == `DMX_Q4 && sel_r == 2'(i) && cyc_r == DMX_CY_PTR1) begin
        ptr_r[i][11:8] <= hi_r; // RULE2
      end else if (q_r == `DMX_Q4 && sel_r == 2'(i) && cyc_r == DMX_CY_PTR2) begin
        ptr_r[i][7:0] <= lo_r; // RULE1
      end
    end
  end

  // One driver for the whole packed output.
  assign indirect_pointer = {ptr_r[2], ptr_r[1], ptr_r[0]};
endmodule
`default_nettype wire

// ### rtl/dmx_regs.svh
`ifndef DMX_REGS_SVH
`define DMX_REGS_SVH

// Quarter phases of one instruction cycle.
`define DMX_Q1 2'h0
`define DMX_Q2 2'h1
`define DMX_Q3 2'h2
`define DMX_Q4 2'h3

// Opcode prefixes and their field positions.
`define DMX_PTR_W1_PFX     10'h3B8
`define DMX_PTR_W1_PFX_MSB 15
`define DMX_PTR_W1_PFX_LSB 6
`define DMX_PTR_SEL_MSB    5
`define DMX_PTR_SEL_LSB    4
`define DMX_PTR_W2_PFX     8'hF0
`define DMX_FMOVE_PFX      6'h14
`define DMX_FMOVE_PFX_LSB  10
`define DMX_FMOVE_D_BIT    9
`define DMX_FMOVE_A_BIT    8
`define DMX_FULL_W1_PFX    4'hC
`define DMX_FULL_W2_PFX    4'hF
`define DMX_NIBBLE_LSB     12

// Access bank mapping.
`define DMX_ACCESS_SPLIT   8'h80
`define DMX_ACCESS_LO_BANK 4'h0
`define DMX_ACCESS_HI_BANK 4'hF

// Reset values and the default working-register address.
`define DMX_PTR_RST   12'h000
`define DMX_W_RST     8'h00
`define DMX_FLAG_RST  1'b0
`define DMX_WREG_DFLT 12'hFFF

`endif

// ### rtl/dmx_pkg.sv
`default_nettype none
package dmx_pkg;
  typedef enum logic [1:0] {
    DMX_OP_NONE,
    DMX_OP_PTR,
    DMX_OP_FMOVE,
    DMX_OP_FULL
  } dmx_op_type;

  typedef enum {
    DMX_EXP_FIRST,
    DMX_EXP_PTR2,
    DMX_EXP_FULL2
  } dmx_exp_type;

  typedef enum {
    DMX_CY_IDLE,
    DMX_CY_PTR1,
    DMX_CY_PTR2,
    DMX_CY_FMOVE,
    DMX_CY_FULL1,
    DMX_CY_FULL2
  } dmx_cyc_type;
endpackage
`default_nettype wire

// ### rtl/dmx_dec_if.sv
`default_nettype none
interface dmx_dec_if;
  import dmx_pkg::*;
  dmx_op_type  op;
  logic        ptr_second;
  logic        full_second;
  logic [1:0]  ptr_sel;
  logic [3:0]  imm_hi;
  logic [7:0]  low_byte;
  logic        dest_bit;
  logic        bank_bit;
  logic [11:0] addr12;
  modport dec (output op, ptr_second, full_second, ptr_sel, imm_hi, low_byte,
               dest_bit, bank_bit, addr12);
  modport exe (input op, ptr_second, full_second, ptr_sel, imm_hi, low_byte,
               dest_bit, bank_bit, addr12);
endinterface
`default_nettype wire

// ### rtl/dmx_decoder.sv
`include "dmx_regs.svh"
`default_nettype none
module dmx_decoder
  import dmx_pkg::*;
(
  // Instruction word
  input  wire logic [15:0] word,
  // Decoded fields
  dmx_dec_if.dec           dec
);
  always_comb begin
    dec.op = DMX_OP_NONE;
    if (word[`DMX_PTR_W1_PFX_MSB:`DMX_PTR_W1_PFX_LSB] == `DMX_PTR_W1_PFX) begin
      dec.op = DMX_OP_PTR; // RULE2
    end else if (word[15:`DMX_FMOVE_PFX_LSB] == `DMX_FMOVE_PFX) begin
      dec.op = DMX_OP_FMOVE; // RULE3
    end else if (word[15:`DMX_NIBBLE_LSB] == `DMX_FULL_W1_PFX) begin
      dec.op = DMX_OP_FULL; // RULE6
    end
  end

  assign dec.ptr_second  = (word[15:8] == `DMX_PTR_W2_PFX);
  assign dec.full_second = (word[15:`DMX_NIBBLE_LSB] == `DMX_FULL_W2_PFX); // RULE6
  assign dec.ptr_sel     = word[`DMX_PTR_SEL_MSB:`DMX_PTR_SEL_LSB];
  assign dec.imm_hi      = word[3:0];
  assign dec.low_byte    = word[7:0];
  assign dec.dest_bit    = word[`DMX_FMOVE_D_BIT];
  assign dec.bank_bit    = word[`DMX_FMOVE_A_BIT];
  assign dec.addr12      = word[11:0];
endmodule
`default_nettype wire

// ### testbench/dmx_exec_chk.sv
`default_nettype none
module dmx_exec_chk #(
  parameter logic [11:0] WREG_ADDR = 12'hFFF
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              srst,
  // Instruction stream and bank selection
  input wire logic [15:0]       instr_word,
  input wire logic              instr_valid,
  input wire logic              instr_take,
  input wire logic [1:0]        q_phase,
  input wire logic [7:0]        bank_select_reg,
  // Data space
  input wire logic [11:0]       mem_addr,
  input wire logic              mem_rd,
  input wire logic [7:0]        mem_rdata,
  input wire logic              mem_wr,
  input wire logic [7:0]        mem_wdata,
  // State
  input wire logic [7:0]        w_reg,
  input wire logic              flag_n,
  input wire logic              flag_z,
  input wire logic [2:0][11:0]  indirect_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_take; instr_take |-> q_phase == 2'h0 && instr_valid; endproperty
  property p_gap; instr_take |=> !instr_take [*3]; endproperty
  property p_rdq; mem_rd |-> q_phase == 2'h1; endproperty
  property p_wrq; mem_wr |-> q_phase == 2'h3; endproperty
  property p_wrw; mem_wr |-> mem_addr != WREG_ADDR; endproperty
  property p_ptrq; $changed(indirect_pointer) |-> $past(q_phase) == 2'h3; endproperty
  property p_ptrfl;
    $changed(indirect_pointer) |-> $stable(flag_n) && $stable(flag_z);
  endproperty
  property p_flq; $changed({flag_n, flag_z}) |-> $past(q_phase) == 2'h3; endproperty
  // The moved byte is the write data when it went to memory, else the working register.
  property p_flv;
    $changed({flag_n, flag_z}) |-> {flag_n, flag_z} == ($past(mem_wr) ?
      {$past(mem_wdata[7]), $past(mem_wdata) == 8'h00} : {w_reg[7], w_reg == 8'h00});
  endproperty
  a_take: assert property (p_take) else $error("take outside first quarter");
  a_gap: assert property (p_gap) else $error("two takes in one cycle");
  a_rdq: assert property (p_rdq) else $error("read outside second quarter");
  a_wrq: assert property (p_wrq) else $error("write outside last quarter");
  a_wrw: assert property (p_wrw) else $error("memory write at working register");
  a_ptrq: assert property (p_ptrq) else $error("pointer changed mid cycle");
  a_ptrfl: assert property (p_ptrfl) else $error("pointer load touched flags");
  a_flq: assert property (p_flq) else $error("flags changed mid cycle");
  a_flv: assert property (p_flv) else $error("flags disagree with byte");
  c_wr: cover property (mem_wr);
  c_ptr: cover property ($changed(indirect_pointer));
  c_fl: cover property ($changed(flag_z));
endmodule
bind dmx_exec dmx_exec_chk #(.WREG_ADDR(WREG_ADDR)) dmx_exec_chk_i (.ref_clk, .srst,
  .instr_word, .instr_valid, .instr_take, .q_phase, .bank_select_reg, .mem_addr, .mem_rd,
  .mem_rdata, .mem_wr, .mem_wdata, .w_reg, .flag_n, .flag_z, .indirect_pointer);
`default_nettype wire

// ### testbench/tb.sv
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic              ref_clk = 0;
  logic              srst = 1;
  logic              instr_valid = 0;
  logic [15:0]       instr_word = 16'h0000;
  logic [7:0]        bank_select_reg = 8'h00;
  logic              instr_take, mem_rd, mem_wr, flag_n, flag_z;
  logic [1:0]        q_phase;
  logic [7:0]        mem_rdata, mem_wdata, w_reg, wd;
  logic [11:0]       mem_addr, wa;
  logic [2:0][11:0]  indirect_pointer, ep;
  logic [7:0]        mem [4096];
  int                err_count = 0, n_checks = 0, wn = 0, rn = 0, cyc = 0;

  dmx_exec #(.WREG_ADDR(12'hFFF)) dmx_exec_i (.ref_clk, .srst, .instr_word, .instr_valid,
    .instr_take, .q_phase, .bank_select_reg, .mem_addr, .mem_rd, .mem_rdata, .mem_wr,
    .mem_wdata, .w_reg, .flag_n, .flag_z, .indirect_pointer);

  always #12.5 ref_clk = ~ref_clk;
  // Outside a read strobe the data lines show the inverse, so stale data cannot pass.
  always_comb mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];
  always @(negedge ref_clk) begin
    cyc++;
    if (mem_wr) begin
      wa = mem_addr;
      wd = mem_wdata;
      wn++;
    end
    if (mem_rd) rn++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Offers one word at the next first quarter and returns once its last quarter is over.
  task automatic issue(input logic [15:0] w);
    while (q_phase !== 2'h0) @(posedge ref_clk) #1;
    instr_word = w;
    instr_valid = 1;
    #1 `CHK("take", 1'b1, instr_take)
    @(posedge ref_clk) #1;
    instr_valid = 0;
    instr_word = 16'($urandom);
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    logic [11:0] k, s, t, a12;
    logic [7:0]  b, f, w0;
    logic [1:0]  sel, da, fl;
    int          wn0, rn0;
    void'($urandom(66));
    foreach (mem[i]) mem[i] = 8'($urandom);
    ep = '0;
    repeat (2) @(posedge ref_clk);
    #1 srst = 0;
    for (int i = 0; i < 8; i++) begin
      sel = i[1:0];
      k = (i < 4) ? {12{i[0]}} : 12'($urandom);
      issue({8'hEE, 2'b00, sel, k[11:8]});
      if (sel != 2'h3) ep[sel][11:8] = k[11:8];
      `CHK("ptr_hi", ep, indirect_pointer)
      issue({8'hF0, k[7:0]});
      if (sel != 2'h3) ep[sel][7:0] = k[7:0];
      `CHK("ptr", ep, indirect_pointer)
    end
    for (int i = 0; i < 24; i++) begin
      f = (i < 2) ? {i[0], 7'h7F} : 8'($urandom);
      da = 2'($urandom);
      bank_select_reg = 8'($urandom);
      a12 = da[0] ? {bank_select_reg[3:0], f} : {f[7] ? 4'hF : 4'h0, f};
      if (i < 4) mem[a12] = {i[0], 7'h00};
      b = (a12 == 12'hFFF) ? w_reg : mem[a12];
      wn0 = wn;
      issue({6'h14, da, f});
      if (da[1] && a12 != 12'hFFF) begin
        `CHK("wr_addr", a12, wa)
        `CHK("wr_data", b, wd)
      end else `CHK("w", b, w_reg)
      `CHK("wr_cnt", wn0 + (da[1] && a12 != 12'hFFF), wn)
      `CHK("flags", {b[7], b == 8'h00}, {flag_n, flag_z})
    end
    for (int i = 0; i < 16; i++) begin
      s = (i == 0) ? 12'hFFF : (i == 2) ? 12'h000 : 12'($urandom);
      // Targets other than the working register are plain bench memory: no counter, stack or interrupt bytes live there.
      t = (i == 1) ? 12'hFFF : (i == 3) ? 12'h000 : 12'($urandom);
      b = (s == 12'hFFF) ? w_reg : mem[s];
      w0 = w_reg;
      fl = {flag_n, flag_z};
      wn0 = wn;
      rn0 = rn;
      issue({4'hC, s});
      // Pass 4 leaves one instruction cycle empty; pass 5 sends a second word of the wrong kind.
      if (i == 4) begin
        repeat (4) @(posedge ref_clk);
        #1;
      end
      issue({(i == 5) ? 4'hE : 4'hF, t});
      if (i == 5) `CHK("drop_w", w0, w_reg)
      else if (t == 12'hFFF) `CHK("w", b, w_reg)
      else begin
        `CHK("wr_addr", t, wa)
        `CHK("wr_data", b, wd)
        mem[t] = b;
      end
      `CHK("rd_cnt", rn0 + (s != 12'hFFF), rn)
      `CHK("wr_cnt", wn0 + (t != 12'hFFF && i != 5), wn)
      `CHK("flags", fl, {flag_n, flag_z})
    end
    srst = 1;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("rst_ptr", 36'h0, indirect_pointer)
    `CHK("rst_w", 8'h00, w_reg)
    `CHK("rst_fl", 2'b00, {flag_n, flag_z})
    `CHK("rst_q", 2'h0, q_phase)
    srst = 0;
    issue({8'hEE, 2'b00, 2'b01, 4'hA});
    `CHK("rst_ptr_hi", {12'h000, 12'hA00, 12'h000}, indirect_pointer)
    print_verdict();
  end
endmodule
`default_nettype wire
